// [rtl/lcd_regs_pkg.sv]
/*
 lcd_regs_pkg: word indices, field positions, reset values and display modes
 of the LCD driver control register bank.
 Assumes a Wishbone slave that turns byte address bits [16:2] into an index.
*/
package lcd_regs_pkg;
   localparam int IDX_W = 15;
   localparam int ADR_W = 17;
   localparam int REG_W = 8;
   localparam int WB_DW = 32;
   localparam logic [14:0] IDX_DISPLAY_CONTROL = 15'h50A0;
   localparam logic [14:0] IDX_CONTRAST_ADJUST = 15'h50A1;
   localparam logic [14:0] IDX_DUTY_SELECT = 15'h50A2;
   localparam logic [14:0] IDX_VOLTAGE_REGULATOR = 15'h50A3;
   localparam logic [14:0] IDX_POWER_BOOSTER = 15'h50A4;
   localparam logic [14:0] IDX_FRAME_IRQ_MASK = 15'h50A5;
   localparam logic [14:0] IDX_FRAME_IRQ_FLAG = 15'h50A6;
   localparam logic [14:0] IDX_PANEL_CLOCK = 15'h5063;
   localparam int SEG_ORDER_BIT = 7;
   localparam int COM_ORDER_BIT = 6;
   localparam int AREA_SEL_BIT = 5;
   localparam int INVERT_BIT = 4;
   localparam int MODE_LSB = 0;
   localparam int CONTRAST_LSB = 0;
   localparam int DUTY_LSB = 0;
   localparam int HEAVY_LOAD_BIT = 4;
   localparam int REG_SOURCE_BIT = 1;
   localparam int BOOSTER_BIT = 0;
   localparam int FRAME_IE_BIT = 0;
   localparam int FRAME_IF_BIT = 0;
   localparam int CLK_DIV_LSB = 2;
   localparam int CLK_SRC_BIT = 1;
   localparam int CLK_EN_BIT = 0;
   localparam logic SEG_ORDER_RST = 1'h1;
   localparam logic COM_ORDER_RST = 1'h1;
   localparam logic AREA_SEL_RST = 1'h0;
   localparam logic INVERT_RST = 1'h1;
   localparam logic [3:0] CONTRAST_RST = 4'h0;
   localparam logic [1:0] DUTY_RST = 2'h2;
   localparam logic HEAVY_LOAD_RST = 1'h0;
   localparam logic REG_SOURCE_RST = 1'h0;
   localparam logic BOOSTER_RST = 1'h0;
   localparam logic FRAME_IE_RST = 1'h0;
   localparam logic FRAME_IF_RST = 1'h0;
   localparam logic [2:0] CLK_DIV_RST = 3'h0;
   localparam logic CLK_SRC_RST = 1'h1;
   localparam logic CLK_EN_RST = 1'h0;
   typedef enum logic [3:0] {
      MODE_OFF = 4'h1,
      MODE_NORMAL = 4'h2,
      MODE_ALL_ON = 4'h4,
      MODE_ALL_OFF = 4'h8
   } display_mode_t;
endpackage

// [rtl/reg_access_if.sv]
/*
 reg_access_if: one-cycle register access strobes between the Wishbone
 front end and the register bank. Assumes one clock for both ends.
*/
`timescale 1ns/10ps
interface reg_access_if
   import lcd_regs_pkg::*;
;
   logic wr;
   logic rd;
   logic [IDX_W-1:0] index;
   logic [REG_W-1:0] wdata;
   logic [REG_W-1:0] rdata;
   modport front (output wr, output rd, output index, output wdata, input rdata);
   modport regs (input wr, input rd, input index, input wdata, output rdata);
endinterface

// [rtl/wb_slave_front.sv]
/*
 wb_slave_front: classic Wishbone slave, one wait state, registered ack and data.
 Assumes the master holds its request until it samples ack.
*/
`timescale 1ns/10ps
module wb_slave_front
   import lcd_regs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [WB_DW-1:0] dat_i,
   output logic ack_o,
   output logic [WB_DW-1:0] dat_o,
   reg_access_if.front bus
);
   typedef struct packed {
      logic ack;
      logic [REG_W-1:0] data;
   } front_t;
   front_t q, next_q;
   logic request;
   // ack blocks a second strobe for the same held request
   assign request = cyc_i && stb_i && !q.ack;
   assign bus.wr = request && we_i && sel_i[0];
   assign bus.rd = request && !we_i;
   assign bus.index = adr_i[ADR_W-1:2];
   assign bus.wdata = dat_i[REG_W-1:0];
   always_comb begin
      next_q = q;
      next_q.ack = request;
      if (bus.rd) begin
         next_q.data = bus.rdata;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) q <= '0;
      else if (ce_i) q <= next_q;
   end
   assign ack_o = q.ack;
   assign dat_o = WB_DW'(q.data);
   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.ack && ce_i) |=> !q.ack) else $error("ack held longer than one cycle");
endmodule // wb_slave_front

// [rtl/frame_irq_unit.sv]
/*
 frame_irq_unit: sticky frame flag and the level interrupt it raises.
 Assumes event_i and clear_i are one-cycle pulses on clk_i.
*/
`timescale 1ns/10ps
module frame_irq_unit (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic event_i,
   input wire logic clear_i,
   input wire logic enable_i,
   output logic flag_o,
   output logic irq_o
);
   typedef struct packed {
      logic flag;
      logic irq;
   } irq_state_t;
   irq_state_t q, next_q;
   always_comb begin
      next_q = q;
      next_q.flag = (q.flag && !clear_i) || event_i;
      next_q.irq = next_q.flag && enable_i;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) q <= '0;
      else if (ce_i) q <= next_q;
   end
   assign flag_o = q.flag;
   assign irq_o = q.irq;
   a_flag_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && event_i) |=> flag_o) else $error("frame event lost");
endmodule // frame_irq_unit

// [rtl/lcd_driver_control_regs.sv]
/*
 lcd_driver_control_regs: control and status register bank of the segment LCD
 driver, reached over classic Wishbone with 8-bit registers in the low byte.
 Assumes frame_event_i is a one-cycle pulse from the drive timing logic and
 that the waveform, memory and analog circuits consume the outputs.
*/
`timescale 1ns/10ps
module lcd_driver_control_regs
   import lcd_regs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [WB_DW-1:0] dat_i,
   output logic ack_o,
   output logic [WB_DW-1:0] dat_o,
   input wire logic frame_event_i,
   output logic segment_order_normal_o,
   output logic common_order_normal_o,
   output logic display_memory_area_sel_o,
   output logic display_invert_normal_o,
   output logic [3:0] display_mode_o,
   output logic [3:0] contrast_level_o,
   output logic [1:0] drive_duty_field_o,
   output logic heavy_load_protect_o,
   output logic regulator_source_sel_o,
   output logic booster_on_o,
   output logic panel_clock_source_sel_o,
   output logic panel_clock_enable_o,
   output logic [2:0] panel_clock_div_o,
   output logic irq_o
);
   typedef struct packed {
      logic seg_normal;
      logic com_normal;
      logic area_sel;
      logic invert_normal;
      display_mode_t mode;
      logic [3:0] contrast;
      logic [1:0] duty;
      logic heavy_load;
      logic reg_source;
      logic booster;
      logic irq_enable;
      logic [2:0] clk_div;
      logic clk_source;
      logic clk_enable;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '{
      seg_normal: SEG_ORDER_RST,
      com_normal: COM_ORDER_RST,
      area_sel: AREA_SEL_RST,
      invert_normal: INVERT_RST,
      mode: MODE_OFF,
      contrast: CONTRAST_RST,
      duty: DUTY_RST,
      heavy_load: HEAVY_LOAD_RST,
      reg_source: REG_SOURCE_RST,
      booster: BOOSTER_RST,
      irq_enable: FRAME_IE_RST,
      clk_div: CLK_DIV_RST,
      clk_source: CLK_SRC_RST,
      clk_enable: CLK_EN_RST
   };

   // field value to one-hot mode; unknown codes fall back to off
   function automatic display_mode_t mode_decode(input logic [1:0] field);
      display_mode_t m;
      m = MODE_OFF;
      case (field)
         2'h0: m = MODE_OFF;
         2'h1: m = MODE_NORMAL;
         2'h2: m = MODE_ALL_ON;
         2'h3: m = MODE_ALL_OFF;
         default: m = MODE_OFF;
      endcase
      return m;
   endfunction

   function automatic logic [1:0] mode_encode(input display_mode_t m);
      logic [1:0] field;
      field = 2'h0;
      case (m)
         MODE_OFF: field = 2'h0;
         MODE_NORMAL: field = 2'h1;
         MODE_ALL_ON: field = 2'h2;
         MODE_ALL_OFF: field = 2'h3;
         default: field = 2'h0;
      endcase
      return field;
   endfunction

   function automatic logic hits(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] reg_idx);
      return idx == reg_idx;
   endfunction

   reg_access_if bus ();
   ctrl_t q, next_q;
   logic frame_flag;
   logic clear_flag;
   logic [REG_W-1:0] read_value;

   wb_slave_front front (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .we_i(we_i),
      .adr_i(adr_i),
      .sel_i(sel_i),
      .dat_i(dat_i),
      .ack_o(ack_o),
      .dat_o(dat_o),
      .bus(bus.front)
   );

   assign clear_flag = (bus.rd && hits(bus.index, IDX_FRAME_IRQ_FLAG))
      || (bus.wr && hits(bus.index, IDX_FRAME_IRQ_FLAG) && bus.wdata[FRAME_IF_BIT]);

   frame_irq_unit frame_irq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .event_i(frame_event_i),
      .clear_i(clear_flag),
      .enable_i(q.irq_enable),
      .flag_o(frame_flag),
      .irq_o(irq_o)
   );

   always_comb begin
      next_q = q;
      if (bus.wr) begin
         case (bus.index)
            IDX_DISPLAY_CONTROL: begin
               next_q.seg_normal = bus.wdata[SEG_ORDER_BIT];
               next_q.com_normal = bus.wdata[COM_ORDER_BIT];
               next_q.area_sel = bus.wdata[AREA_SEL_BIT];
               next_q.invert_normal = bus.wdata[INVERT_BIT];
               next_q.mode = mode_decode(bus.wdata[MODE_LSB +: 2]);
            end
            IDX_CONTRAST_ADJUST: begin
               next_q.contrast = bus.wdata[CONTRAST_LSB +: 4];
            end
            IDX_DUTY_SELECT: begin
               next_q.duty = bus.wdata[DUTY_LSB +: 2];
            end
            IDX_VOLTAGE_REGULATOR: begin
               next_q.heavy_load = bus.wdata[HEAVY_LOAD_BIT];
            end
            IDX_POWER_BOOSTER: begin
               next_q.reg_source = bus.wdata[REG_SOURCE_BIT];
               next_q.booster = bus.wdata[BOOSTER_BIT];
            end
            IDX_FRAME_IRQ_MASK: begin
               next_q.irq_enable = bus.wdata[FRAME_IE_BIT];
            end
            IDX_PANEL_CLOCK: begin
               next_q.clk_div = bus.wdata[CLK_DIV_LSB +: 3];
               next_q.clk_source = bus.wdata[CLK_SRC_BIT];
               next_q.clk_enable = bus.wdata[CLK_EN_BIT];
            end
            default: begin
               next_q = q;
            end
         endcase
      end
   end

   // reserved bits and unmapped indices read as zero
   always_comb begin
      read_value = '0;
      case (bus.index)
         IDX_DISPLAY_CONTROL: begin
            read_value[SEG_ORDER_BIT] = q.seg_normal;
            read_value[COM_ORDER_BIT] = q.com_normal;
            read_value[AREA_SEL_BIT] = q.area_sel;
            read_value[INVERT_BIT] = q.invert_normal;
            read_value[MODE_LSB +: 2] = mode_encode(q.mode);
         end
         IDX_CONTRAST_ADJUST: read_value[CONTRAST_LSB +: 4] = q.contrast;
         IDX_DUTY_SELECT: read_value[DUTY_LSB +: 2] = q.duty;
         IDX_VOLTAGE_REGULATOR: read_value[HEAVY_LOAD_BIT] = q.heavy_load;
         IDX_POWER_BOOSTER: begin
            read_value[REG_SOURCE_BIT] = q.reg_source;
            read_value[BOOSTER_BIT] = q.booster;
         end
         IDX_FRAME_IRQ_MASK: read_value[FRAME_IE_BIT] = q.irq_enable;
         IDX_FRAME_IRQ_FLAG: read_value[FRAME_IF_BIT] = frame_flag;
         IDX_PANEL_CLOCK: begin
            read_value[CLK_DIV_LSB +: 3] = q.clk_div;
            read_value[CLK_SRC_BIT] = q.clk_source;
            read_value[CLK_EN_BIT] = q.clk_enable;
         end
         default: read_value = '0;
      endcase
   end
   assign bus.rdata = read_value;

   always_ff @(posedge clk_i) begin
      if (rst_i) q <= CTRL_RST;
      else if (ce_i) q <= next_q;
   end

   // outputs drive the panel logic straight from the bank
   assign segment_order_normal_o = q.seg_normal;
   assign common_order_normal_o = q.com_normal;
   assign display_memory_area_sel_o = q.area_sel;
   assign display_invert_normal_o = q.invert_normal;
   assign display_mode_o = q.mode;
   assign contrast_level_o = q.contrast;
   assign drive_duty_field_o = q.duty;
   assign heavy_load_protect_o = q.heavy_load;
   assign regulator_source_sel_o = q.reg_source;
   assign booster_on_o = q.booster;
   assign panel_clock_source_sel_o = q.clk_source;
   assign panel_clock_enable_o = q.clk_enable;
   assign panel_clock_div_o = q.clk_div;

   // helper terms for the checks below
   logic wr_dctl;
   logic wr_vreg;
   logic wr_pwr;
   logic wr_clk;
   logic rd_flag;
   logic wdata_seg;
   logic wdata_com;
   logic wdata_heavy;
   logic wdata_src;
   logic wdata_clk_src;
   logic [1:0] wdata_mode;
   assign wr_dctl = ce_i && bus.wr && hits(bus.index, IDX_DISPLAY_CONTROL);
   assign wr_vreg = ce_i && bus.wr && hits(bus.index, IDX_VOLTAGE_REGULATOR);
   assign wr_pwr = ce_i && bus.wr && hits(bus.index, IDX_POWER_BOOSTER);
   assign wr_clk = ce_i && bus.wr && hits(bus.index, IDX_PANEL_CLOCK);
   assign rd_flag = ce_i && bus.rd && hits(bus.index, IDX_FRAME_IRQ_FLAG);
   assign wdata_seg = bus.wdata[SEG_ORDER_BIT];
   assign wdata_com = bus.wdata[COM_ORDER_BIT];
   assign wdata_heavy = bus.wdata[HEAVY_LOAD_BIT];
   assign wdata_src = bus.wdata[REG_SOURCE_BIT];
   assign wdata_clk_src = bus.wdata[CLK_SRC_BIT];
   assign wdata_mode = bus.wdata[MODE_LSB +: 2];

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_seg_order_write: assert property (
      wr_dctl |=> segment_order_normal_o == $past(wdata_seg))
      else $error("segment order bit not taken");
   a_com_order_write: assert property (
      wr_dctl |=> common_order_normal_o == $past(wdata_com))
      else $error("common order bit not taken");
   a_area_sel_hold: assert property (
      !wr_dctl |=> $stable(display_memory_area_sel_o))
      else $error("area select changed without a write");
   a_heavy_load_write: assert property (
      wr_vreg |=> heavy_load_protect_o == $past(wdata_heavy))
      else $error("heavy-load bit not taken");
   a_reg_source_write: assert property (
      wr_pwr |=> regulator_source_sel_o == $past(wdata_src))
      else $error("regulator source bit not taken");
   a_booster_by_write: assert property (
      !$stable(booster_on_o) |-> $past(wr_pwr))
      else $error("booster changed without a write");
   a_irq_mask_gate: assert property (
      (ce_i && !q.irq_enable) |=> !irq_o)
      else $error("interrupt raised while disabled");
   a_flag_read_clear: assert property (
      (rd_flag && !frame_event_i) |=> !frame_flag)
      else $error("flag survived a read");
   a_clock_source_write: assert property (
      wr_clk |=> panel_clock_source_sel_o == $past(wdata_clk_src))
      else $error("clock source bit not taken");
   a_irq_level_high: assert property (
      (ce_i && frame_flag && q.irq_enable && !clear_flag) |=> irq_o)
      else $error("interrupt missing while flag and enable set");
   a_mode_all_on: assert property (
      (wr_dctl && wdata_mode == 2'h2) |=> display_mode_o == MODE_ALL_ON ##1 $onehot(display_mode_o))
      else $error("all-on mode not selected");

   c_flag_read: cover property (frame_flag ##1 rd_flag ##1 !frame_flag);
   c_irq_rise: cover property (!irq_o ##1 irq_o);
   c_mode_all_off: cover property (wr_dctl && wdata_mode == 2'h3);
   c_set_meets_clear: cover property (ce_i && frame_event_i && clear_flag);
endmodule // lcd_driver_control_regs

// [verification/lcd_panel_model.sv]
/*
 lcd_panel_model: stands for the drive timing and panel side of the bank.
 It turns a bench request into a one-cycle frame event on clk_i.
 Assumes the bench raises fire_i for exactly one cycle per frame.
*/
`timescale 1ns/10ps
module lcd_panel_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic fire_i,
   output logic frame_event_o
);
   // frame event source
   // registered so the pulse never lands in the request edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_event_o <= 1'b0;
      end else begin
         frame_event_o <= fire_i;
      end
   end
endmodule // lcd_panel_model

// [verification/lcd_driver_control_regs_bench.sv]
/*
 lcd_driver_control_regs_bench: register access tests of the LCD control bank.
 Assumes a one-wait-state classic Wishbone slave and the panel model beside it.
*/
`timescale 1ns/10ps
module lcd_driver_control_regs_bench
   import lcd_regs_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0;
   logic [ADR_W-1:0] adr = '0;
   logic [3:0] sel = 4'hF;
   logic [WB_DW-1:0] dat = '0;
   logic ack_o, irq_o, frame_event;
   logic [WB_DW-1:0] dat_o;
   logic [21:0] outs;
   int mismatches = 0;
   int compares = 0;
   logic [14:0] idx_tab [7] = '{IDX_DISPLAY_CONTROL, IDX_CONTRAST_ADJUST, IDX_DUTY_SELECT,
      IDX_VOLTAGE_REGULATOR, IDX_POWER_BOOSTER, IDX_FRAME_IRQ_MASK, IDX_PANEL_CLOCK};
   logic [7:0] rst_tab [7] = '{8'hD0, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h02};
   logic [7:0] ones_tab [7] = '{8'hF3, 8'h0F, 8'h03, 8'h10, 8'h03, 8'h01, 8'h1F};

   always #5 clk_i = ~clk_i;

   lcd_panel_model lcd_panel_model_i (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
      .frame_event_o(frame_event));

   lcd_driver_control_regs lcd_driver_control_regs_i (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(dat), .ack_o(ack_o), .dat_o(dat_o), .frame_event_i(frame_event),
      .segment_order_normal_o(outs[21]), .common_order_normal_o(outs[20]),
      .display_memory_area_sel_o(outs[19]), .display_invert_normal_o(outs[18]),
      .display_mode_o(outs[17:14]), .contrast_level_o(outs[13:10]),
      .drive_duty_field_o(outs[9:8]), .heavy_load_protect_o(outs[7]),
      .regulator_source_sel_o(outs[6]), .booster_on_o(outs[5]),
      .panel_clock_source_sel_o(outs[4]), .panel_clock_enable_o(outs[3]),
      .panel_clock_div_o(outs[2:0]), .irq_o(irq_o));

   task automatic wrap_up();
      if (mismatches == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // one classic cycle; the request holds until ack is sampled
   task automatic wb(input logic w, input logic [14:0] i, input logic [7:0] d,
      input logic [3:0] s, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      dat <= {24'h000000, d};
      sel <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         wrap_up();
      end
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [14:0] i, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, i, d, 4'hF, q);
   endtask

   task automatic rd(input logic [14:0] i, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'b0, i, 8'h00, 4'hF, q);
      check($sformatf("reg %h", i), {24'h000000, exp}, {24'h000000, q});
   endtask

   task automatic frame();
      @(posedge clk_i);
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
      tick(3);
   endtask

   initial begin
      logic [7:0] q;
      tick(12);
      rst_i <= 1'b0;
      tick(2);
      check("reset outputs", 32'h344210, {10'h000, outs});
      check("reset irq", 32'h0, {31'h0, irq_o});
      for (int k = 0; k < 7; k++) begin
         rd(idx_tab[k], rst_tab[k]);
      end
      rd(IDX_FRAME_IRQ_FLAG, 8'h00);
      for (int k = 0; k < 7; k++) begin
         wr(idx_tab[k], 8'hFF);
         rd(idx_tab[k], ones_tab[k]);
      end
      check("all ones outputs", 32'h3E3FFF, {10'h000, outs});
      for (int k = 0; k < 7; k++) begin
         wr(idx_tab[k], 8'h00);
         rd(idx_tab[k], 8'h00);
      end
      check("all zero outputs", 32'h004000, {10'h000, outs});
      for (int m = 0; m < 4; m++) begin
         wr(IDX_DISPLAY_CONTROL, 8'hD0 | 8'(m));
         rd(IDX_DISPLAY_CONTROL, 8'hD0 | 8'(m));
         check("mode", 32'h1 << m, {28'h0, outs[17:14]});
      end
      wr(15'h50A7, 8'hFF);
      rd(15'h50A7, 8'h00);
      wb(1'b1, IDX_CONTRAST_ADJUST, 8'hFF, 4'hE, q);
      rd(IDX_CONTRAST_ADJUST, 8'h00);
      // masked frame: flag set, no request
      frame();
      check("masked irq", 32'h0, {31'h0, irq_o});
      rd(IDX_FRAME_IRQ_FLAG, 8'h01);
      rd(IDX_FRAME_IRQ_FLAG, 8'h00);
      frame();
      wr(IDX_FRAME_IRQ_FLAG, 8'h00);
      wr(IDX_FRAME_IRQ_MASK, 8'h01);
      tick(2);
      check("irq after unmask", 32'h1, {31'h0, irq_o});
      wr(IDX_FRAME_IRQ_FLAG, 8'h01);
      tick(2);
      check("irq after clear", 32'h0, {31'h0, irq_o});
      rd(IDX_FRAME_IRQ_FLAG, 8'h00);
      frame();
      check("irq on frame", 32'h1, {31'h0, irq_o});
      wr(IDX_FRAME_IRQ_MASK, 8'h00);
      tick(2);
      check("irq after mask", 32'h0, {31'h0, irq_o});
      wr(IDX_FRAME_IRQ_MASK, 8'h01);
      tick(2);
      check("irq remask", 32'h1, {31'h0, irq_o});
      rd(IDX_FRAME_IRQ_FLAG, 8'h01);
      tick(2);
      check("irq after read", 32'h0, {31'h0, irq_o});
      wrap_up();
   end

   // watchdog against a hang outside the bus waits
   initial begin
      tick(20000);
      mismatches++;
      wrap_up();
   end
endmodule // lcd_driver_control_regs_bench
